// >>> gpt_core.sv
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "gpt_defs.svh"
// Summary of operation
// RULE1 - slave off: prescaler runs on timer clock
// RULE2 - ext mode 1: channel triggers, ch1 double edge
// RULE3 - ext mode 2: trigger pin polarity, divide, filter
// RULE4 - internal triggers unfiltered; master resets/starts/clocks
// RULE5 - counter, reload, prescaler sixteen bits each
// RULE6 - up: count from zero, wrap at reload
// RULE7 - down: from reload to zero, then reload
// RULE8 - centre: overflow at reload-1, underflow at one
// RULE9 - direction field selects up, down, centre
// RULE10 - update event loads reload shadow and prescaler
// RULE11 - update-disable bit suppresses update events
// RULE12 - prescaler divides by one to 65536, buffered
// RULE13 - four independent capture/compare channels
// RULE14 - capture: edge detect, filter, event prescaler
// RULE15 - capture latches count, sets flag, interrupt
// RULE16 - eight output compare modes per channel
// RULE17 - match drives output per mode and polarity
// RULE18 - flag raises interrupt and optional dma request
// RULE19 - pwm period from reload, width from compare
// RULE20 - pwm1: active while count below compare
// RULE21 - pwm2: inactive while count below compare
// RULE22 - slave codes: reset 100, gated 101, trigger 110
// RULE23 - modes 100/101 force reference inactive/active
// RULE24 - new prescale ratio waits for update event
// RULE25 - forced and frozen modes still flag matches
module gpt_core #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire gpt_pkg::gpt_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // timer pins and other timers
  input wire logic [3:0] ch_in,
  input wire logic external_trigger_pin,
  input wire logic [3:0] itr_in,
  // channel outputs
  output logic [3:0] ch_out,
  output logic [3:0] ch_oe,
  // events
  output logic irq,
  output logic dma_req,
  output logic trgo
);
  // software registers
  logic [31:0] ctrl1_q, ctrl2_q, smctrl_q, dien_q, ccm_q, ccen_q;
  logic [CW-1:0] cnt_q, cnt_d; // count_value
  logic [CW-1:0] psc_buf_q, psc_act_q, pc_q; // prescale_value and shadow
  logic [CW-1:0] arr_buf_q, arr_sh_q; // reload_value and shadow
  logic [CW-1:0] ccr_q [4]; // channel_compare_value per channel
  logic uif_q;
  logic [3:0] ccif_q; // channel_event_flag
  gpt_pkg::gpt_phase_t ph_q, ph_d;
  // bus handshake
  logic ack_q, wr, acc;
  logic [6:0] adr;
  // decoded controls
  gpt_pkg::gpt_cmode_t cmode;
  gpt_pkg::gpt_smode_t smode;
  logic ud, dma_on_compare_select, ece, etrpol;
  logic [1:0] etrdiv;
  logic [3:0] filt, tsel, pol, capsel;
  // trigger path
  logic [4:0] flt_raw, flt_q;
  logic [3:0] tif_q;
  logic etr_p_q, etr_div, etrf;
  logic [2:0] etr_cnt_q;
  logic trig_lvl, trig_q, trig_rise, dbl_pulse, etrf_q;
  // counting
  logic prescaler_clock_in, tick, ovf, udf, ug, slv_rst, uev, chg_q;
  logic [3:0] cap_ev, match_ev, ref_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // next reference level for one channel from its output_mode_field
  function automatic logic oc_next(input logic [2:0] md, input logic rf,
    input logic hit, input logic lt);
    case (md)
      3'b000: return rf; // freeze
      3'b001: return hit ? 1'b1 : rf;
      3'b010: return hit ? 1'b0 : rf;
      3'b011: return hit ? ~rf : rf;
      3'b100: return 1'b0; // see RULE23
      3'b101: return 1'b1; // see RULE23
      3'b110: return lt; // see RULE20
      3'b111: return ~lt; // see RULE21
      default: return rf;
    endcase
  endfunction

  // field decode
  assign cmode = gpt_pkg::gpt_cmode_t'(ctrl1_q[`GPT_DIR_LO +: 2]);
  assign ud = ctrl1_q[`GPT_UD];
  assign dma_on_compare_select = ctrl2_q[`GPT_DMA_ON_COMPARE_SELECT];
  assign smode = gpt_pkg::gpt_smode_t'(smctrl_q[2:0]);
  assign tsel = smctrl_q[7:4];
  assign etrpol = smctrl_q[`GPT_ETRPOL];
  assign etrdiv = smctrl_q[`GPT_ETRDIV_LO +: 2];
  assign filt = smctrl_q[`GPT_FILT_LO +: 4];
  assign ece = smctrl_q[`GPT_ECE];
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      capsel[i] = ccm_q[8*i];
      pol[i] = ccen_q[4*i+1];
    end
  end

  // one wait cycle on every access; the answer comes on the second edge
  assign acc = avs_req.read | avs_req.write;
  assign avs_waitrequest = acc & ~ack_q;
  assign wr = avs_req.write & ack_q;
  assign adr = {avs_req.address[6:2], 2'b00};
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= acc & ~ack_q;
  end

  // read mux; unmapped offsets read as zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_req.read & ~ack_q)
    begin
      case (adr)
        `GPT_OFS_CTRL1: avs_readdata <= {ctrl1_q[31:5], ph_q,
                                         ctrl1_q[3:0]};
        `GPT_OFS_CTRL2: avs_readdata <= ctrl2_q;
        `GPT_OFS_SMCTRL: avs_readdata <= smctrl_q;
        `GPT_OFS_DIEN: avs_readdata <= dien_q;
        `GPT_OFS_STS: avs_readdata <= {27'h0, ccif_q, uif_q};
        `GPT_OFS_CCM: avs_readdata <= ccm_q;
        `GPT_OFS_CCEN: avs_readdata <= ccen_q;
        `GPT_OFS_CNT: avs_readdata <= {16'h0, cnt_q};
        `GPT_OFS_PSC: avs_readdata <= {16'h0, psc_buf_q};
        `GPT_OFS_RELOAD: avs_readdata <= {16'h0, arr_buf_q};
        default:
        begin
          avs_readdata <= 32'h0000_0000;
          for (int i = 0; i < 4; i++)
            if (adr == `GPT_OFS_CC1 + 7'(4*i))
              avs_readdata <= {16'h0, ccr_q[i]};
        end
      endcase
    end
  end

  // control registers; trigger mode lets hardware set the enable bit
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl1_q <= 32'h0;
      ctrl2_q <= 32'h0;
      smctrl_q <= 32'h0;
      dien_q <= 32'h0;
      ccm_q <= 32'h0;
      ccen_q <= 32'h0;
    end
    else
    begin
      if (wr && adr == `GPT_OFS_CTRL1)
        ctrl1_q <= merge(ctrl1_q, avs_req.writedata, avs_req.byteenable)
                   & 32'h0000_000f;
      if (smode == gpt_pkg::GPT_SM_TRIG && trig_rise)
        ctrl1_q[`GPT_CEN] <= 1'b1; // see RULE4 RULE22
      if (wr && adr == `GPT_OFS_CTRL2)
        ctrl2_q <= merge(ctrl2_q, avs_req.writedata, avs_req.byteenable);
      if (wr && adr == `GPT_OFS_SMCTRL)
        smctrl_q <= merge(smctrl_q, avs_req.writedata, avs_req.byteenable);
      if (wr && adr == `GPT_OFS_DIEN)
        dien_q <= merge(dien_q, avs_req.writedata, avs_req.byteenable);
      if (wr && adr == `GPT_OFS_CCM)
        ccm_q <= merge(ccm_q, avs_req.writedata, avs_req.byteenable);
      if (wr && adr == `GPT_OFS_CCEN)
        ccen_q <= merge(ccen_q, avs_req.writedata, avs_req.byteenable);
    end
  end

  // trigger pin: polarity then edge divider (1,2,4,8) then filter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      etr_p_q <= 1'b0;
      etr_cnt_q <= 3'h0;
    end
    else
    begin
      etr_p_q <= external_trigger_pin ^ etrpol;
      if ((external_trigger_pin ^ etrpol) & ~etr_p_q)
        etr_cnt_q <= etr_cnt_q + 3'h1; // see RULE3
    end
  end
  assign etr_div = (etrdiv == 2'h0) ? etr_p_q : etr_cnt_q[etrdiv - 2'h1];

  // shared glitch filter: a level must hold filt+1 cycles to pass
  assign flt_raw = {etr_div, ch_in ^ pol};
  for (genvar g = 0; g < 5; g++)
  begin : g_flt
    logic [3:0] fc_q;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        fc_q <= 4'h0;
        flt_q[g] <= 1'b0;
      end
      else if (flt_raw[g] == flt_q[g])
        fc_q <= 4'h0;
      else if (fc_q >= filt)
      begin
        flt_q[g] <= flt_raw[g]; // see RULE14 RULE3
        fc_q <= 4'h0;
      end
      else
        fc_q <= fc_q + 4'h1;
    end
  end
  assign etrf = flt_q[4];

  // trigger selection; internal triggers bypass any filter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tif_q <= 4'h0;
      trig_q <= 1'b0;
      etrf_q <= 1'b0;
    end
    else
    begin
      tif_q <= flt_q[3:0];
      trig_q <= trig_lvl;
      etrf_q <= etrf;
    end
  end
  assign dbl_pulse = flt_q[0] ^ tif_q[0]; // see RULE2
  always_comb
  begin
    case (tsel)
      4'h0, 4'h1, 4'h2, 4'h3: trig_lvl = itr_in[tsel[1:0]]; // see RULE4
      4'h4, 4'h5, 4'h6, 4'h7: trig_lvl = flt_q[tsel[1:0]]; // see RULE2
      4'h8: trig_lvl = dbl_pulse;
      4'h9: trig_lvl = etrf;
      default: trig_lvl = 1'b0;
    endcase
  end
  assign trig_rise = trig_lvl & ~trig_q;

  // prescaler input clock enable
  always_comb
  begin
    if (ece)
      prescaler_clock_in = etrf & ~etrf_q; // see RULE3
    else
    begin
      case (smode)
        gpt_pkg::GPT_SM_EXT1: prescaler_clock_in = trig_rise; // see RULE2
        gpt_pkg::GPT_SM_GATED: prescaler_clock_in = trig_lvl; // see RULE22
        default: prescaler_clock_in = 1'b1; // see RULE1
      endcase
    end
  end
  assign slv_rst = (smode == gpt_pkg::GPT_SM_RESET) & trig_rise; // see RULE22
  assign ug = wr && adr == `GPT_OFS_EVGEN && avs_req.byteenable[0] &&
              avs_req.writedata[0];
  assign tick = ctrl1_q[`GPT_CEN] & prescaler_clock_in & (pc_q == psc_act_q);

  // counter next state for the three directions
  always_comb
  begin
    cnt_d = cnt_q;
    ph_d = ph_q;
    ovf = 1'b0;
    udf = 1'b0;
    if (slv_rst | ug)
    begin
      // counting down restarts from the reload value rather than zero
      if (cmode == gpt_pkg::GPT_CNT_DOWN)
        cnt_d = ud ? arr_sh_q : arr_buf_q; // see RULE7
      else
        cnt_d = '0;
      ph_d = gpt_pkg::GPT_PH_UP;
    end
    else if (wr && adr == `GPT_OFS_CNT)
      cnt_d = avs_req.writedata[CW-1:0];
    else if (tick)
    begin
      case (cmode) // see RULE9
        gpt_pkg::GPT_CNT_UP:
        begin
          ovf = (cnt_q == arr_sh_q); // see RULE6
          cnt_d = ovf ? '0 : cnt_q + 1'b1;
        end
        gpt_pkg::GPT_CNT_DOWN:
        begin
          udf = (cnt_q == '0); // see RULE7
          cnt_d = udf ? arr_sh_q : cnt_q - 1'b1;
        end
        gpt_pkg::GPT_CNT_CENTER:
          if (ph_q == gpt_pkg::GPT_PH_UP)
          begin
            if (cnt_q >= arr_sh_q)
            begin
              ph_d = gpt_pkg::GPT_PH_DOWN;
              cnt_d = cnt_q - 1'b1;
            end
            else
            begin
              ovf = (cnt_q == arr_sh_q - 1'b1); // see RULE8
              cnt_d = cnt_q + 1'b1;
            end
          end
          else if (cnt_q == '0)
          begin
            ph_d = gpt_pkg::GPT_PH_UP;
            cnt_d = cnt_q + 1'b1;
          end
          else
          begin
            udf = (cnt_q == 16'h0001); // see RULE8
            cnt_d = cnt_q - 1'b1;
          end
        default: cnt_d = cnt_q;
      endcase
    end
  end
  assign uev = ~ud & (ovf | udf | ug | slv_rst); // see RULE10 RULE11

  // counter, phase and prescale counter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      ph_q <= gpt_pkg::GPT_PH_UP;
      pc_q <= '0;
      chg_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      chg_q <= (cnt_d != cnt_q);
      if (slv_rst | ug)
        pc_q <= '0;
      else if (ctrl1_q[`GPT_CEN] & prescaler_clock_in)
        pc_q <= (pc_q == psc_act_q) ? '0 : pc_q + 1'b1; // see RULE12
    end
  end

  // buffered reload and prescale values move to shadows at update
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      psc_buf_q <= '0;
      psc_act_q <= '0;
      arr_buf_q <= `GPT_RST_RELOAD;
      arr_sh_q <= `GPT_RST_RELOAD;
    end
    else
    begin
      if (wr && adr == `GPT_OFS_PSC)
        psc_buf_q <= avs_req.writedata[CW-1:0]; // see RULE12 RULE5
      if (wr && adr == `GPT_OFS_RELOAD)
        arr_buf_q <= avs_req.writedata[CW-1:0];
      if (uev)
      begin
        psc_act_q <= psc_buf_q; // see RULE24
        arr_sh_q <= arr_buf_q; // see RULE10
      end
    end
  end

  // four channels: capture prescaler, compare register, reference
  for (genvar c = 0; c < 4; c++)
  begin : g_ch // see RULE13
    logic [2:0] icp_q;
    logic [1:0] icpsc;
    assign icpsc = ccm_q[8*c+4 +: 2];
    assign cap_ev[c] = capsel[c] & flt_q[c] & ~tif_q[c] &
                       (icp_q == 3'((1 << icpsc) - 1)); // see RULE14
    assign match_ev[c] = ~capsel[c] & chg_q & (cnt_q == ccr_q[c]);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        icp_q <= 3'h0;
        ccr_q[c] <= '0;
        ref_q[c] <= 1'b0;
      end
      else
      begin
        if (!capsel[c])
          icp_q <= 3'h0;
        else if (cap_ev[c])
          icp_q <= 3'h0;
        else if (flt_q[c] & ~tif_q[c])
          icp_q <= icp_q + 3'h1;
        if (cap_ev[c])
          ccr_q[c] <= cnt_q; // see RULE15
        else if (wr && adr == `GPT_OFS_CC1 + 7'(4*c))
          ccr_q[c] <= avs_req.writedata[CW-1:0];
        ref_q[c] <= oc_next(ccm_q[8*c+1 +: 3], ref_q[c], match_ev[c],
                            cnt_q < ccr_q[c]); // see RULE16 RULE19
      end
    end
  end

  // flags: hardware set wins over a write-zero clear
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      uif_q <= 1'b0;
      ccif_q <= 4'h0;
    end
    else
    begin
      if (wr && adr == `GPT_OFS_STS && avs_req.byteenable[0])
      begin
        uif_q <= (uif_q & avs_req.writedata[0]) | uev;
        ccif_q <= (ccif_q & avs_req.writedata[4:1]) | cap_ev | match_ev;
      end
      else
      begin
        uif_q <= uif_q | uev;
        ccif_q <= ccif_q | cap_ev | match_ev; // see RULE15 RULE25
      end
    end
  end

  // outputs, interrupt and dma request
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch_out <= 4'h0;
      ch_oe <= 4'h0;
      irq <= 1'b0;
      dma_req <= 1'b0;
      trgo <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        ch_out[i] <= ref_q[i] ^ pol[i]; // see RULE17
        ch_oe[i] <= ccen_q[4*i] & ~capsel[i];
      end
      irq <= |(ccif_q & dien_q[`GPT_CCIE_LO +: 4]) |
             (uif_q & dien_q[`GPT_UIE]); // see RULE18
      dma_req <= dma_on_compare_select ? |((cap_ev | match_ev) &
                            dien_q[`GPT_CCDE_LO +: 4])
                        : (uev & dien_q[`GPT_UDE]); // see RULE18
      trgo <= uev; // update pulse for a slave timer
    end
  end

  // checks
  // a software count write in the same cycle takes priority over a tick
  sequence s_up_top;
    tick && cmode == gpt_pkg::GPT_CNT_UP && cnt_q == arr_sh_q &&
    !slv_rst && !ug && !ud && !(wr && adr == `GPT_OFS_CNT);
  endsequence
  sequence s_down_zero;
    tick && cmode == gpt_pkg::GPT_CNT_DOWN && cnt_q == '0 &&
    !slv_rst && !ug && !(wr && adr == `GPT_OFS_CNT);
  endsequence
  property p_up_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    s_up_top |=> cnt_q == '0 && uif_q;
  endproperty
  a_up_wrap: assert property (p_up_wrap) // see RULE6
    else $error("up count did not wrap to zero");
  property p_down_reload;
    @(posedge sys_clk) disable iff (!rst_n)
    s_down_zero |=> cnt_q == $past(arr_sh_q);
  endproperty
  a_down_reload: assert property (p_down_reload) // see RULE7
    else $error("down count did not reload");
  property p_ud_block;
    @(posedge sys_clk) disable iff (!rst_n)
    ud && arr_sh_q != arr_buf_q |=> arr_sh_q == $past(arr_sh_q);
  endproperty
  a_ud_block: assert property (p_ud_block) // see RULE11
    else $error("shadow changed while updates disabled");
  property p_psc_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !uev |=> psc_act_q == $past(psc_act_q);
  endproperty
  a_psc_hold: assert property (p_psc_hold) // see RULE24
    else $error("prescale ratio changed without update");
  property p_capture;
    @(posedge sys_clk) disable iff (!rst_n)
    cap_ev[1] |=> ccr_q[1] == $past(cnt_q) && ccif_q[1];
  endproperty
  a_capture: assert property (p_capture) // see RULE15
    else $error("capture did not latch count and flag");
  property p_pwm1;
    @(posedge sys_clk) disable iff (!rst_n)
    ccm_q[3:1] == 3'b110 && !capsel[0] |=>
      ref_q[0] == ($past(cnt_q) < $past(ccr_q[0])) ##1
      ch_out[0] == ($past(ref_q[0]) ^ $past(pol[0]));
  endproperty
  a_pwm1: assert property (p_pwm1) // see RULE20
    else $error("pwm1 reference wrong");
  property p_force;
    @(posedge sys_clk) disable iff (!rst_n)
    ccm_q[3:1] == 3'b100 [*2] |-> ref_q[0] == 1'b0;
  endproperty
  a_force: assert property (p_force) // see RULE23
    else $error("forced inactive reference not low");
  property p_center_ovf;
    @(posedge sys_clk) disable iff (!rst_n)
    tick && cmode == gpt_pkg::GPT_CNT_CENTER && ph_q == gpt_pkg::GPT_PH_UP
      && cnt_q == arr_sh_q - 1'b1 && !ud && !slv_rst && !ug
      && arr_sh_q != '0 && !(wr && adr == `GPT_OFS_CNT)
      |=> uif_q && cnt_q == arr_sh_q;
  endproperty
  a_center_ovf: assert property (p_center_ovf) // see RULE8
    else $error("centre overflow missing at reload-1");
  property p_uev_load;
    @(posedge sys_clk) disable iff (!rst_n)
    uev |=> arr_sh_q == $past(arr_buf_q) && psc_act_q == $past(psc_buf_q)
      && trgo;
  endproperty
  a_uev_load: assert property (p_uev_load) // see RULE10
    else $error("update did not load shadows");
endmodule

// >>> gpt_defs.svh
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH
// register byte offsets
`define GPT_OFS_CTRL1 7'h00
`define GPT_OFS_CTRL2 7'h04
`define GPT_OFS_SMCTRL 7'h08
`define GPT_OFS_DIEN 7'h0c
`define GPT_OFS_STS 7'h10
`define GPT_OFS_EVGEN 7'h14
`define GPT_OFS_CCM 7'h18
`define GPT_OFS_CCEN 7'h20
`define GPT_OFS_CNT 7'h24
`define GPT_OFS_PSC 7'h28
`define GPT_OFS_RELOAD 7'h2c
`define GPT_OFS_CC1 7'h34
// control_reg_one fields
`define GPT_CEN 0
`define GPT_UD 1
`define GPT_DIR_LO 2
`define GPT_DIR_ST 4
// control_reg_two field
`define GPT_DMA_ON_COMPARE_SELECT 3
// slave control fields
`define GPT_ETRPOL 8
`define GPT_ETRDIV_LO 9
`define GPT_FILT_LO 12
`define GPT_ECE 16
// irq_dma_enable_reg and status_reg fields
`define GPT_UIE 0
`define GPT_CCIE_LO 1
`define GPT_UDE 8
`define GPT_CCDE_LO 9
// reset values
`define GPT_RST_RELOAD 16'hffff
`endif

// >>> gpt_pkg.sv
package gpt_pkg;
  // avalon-mm request from the bus master
  typedef struct packed {
    logic read;
    logic write;
    logic [6:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } gpt_avs_req_t;
  // count_direction_sel codes
  typedef enum logic [1:0] {
    GPT_CNT_UP = 2'b00,
    GPT_CNT_DOWN = 2'b01,
    GPT_CNT_CENTER = 2'b10
  } gpt_cmode_t;
  // slave_mode_field codes
  typedef enum logic [2:0] {
    GPT_SM_OFF = 3'b000,
    GPT_SM_RESET = 3'b100,
    GPT_SM_GATED = 3'b101,
    GPT_SM_TRIG = 3'b110,
    GPT_SM_EXT1 = 3'b111
  } gpt_smode_t;
  // centre-aligned phase
  typedef enum logic {
    GPT_PH_UP = 1'b0,
    GPT_PH_DOWN = 1'b1
  } gpt_phase_t;
endpackage

// >>> gpt_pin_model.sv
`timescale 1ns/10ps
// far side of the timer: channel pins, trigger pin and other timers
module gpt_pin_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // levels asked for by the bench
  input wire logic [3:0] ch_set,
  input wire logic [3:0] itr_set,
  input wire logic ext_set,
  // pins toward the timer
  output logic [3:0] ch_in,
  output logic [3:0] itr_in,
  output logic external_trigger_pin
);
  // pins are push-pull and registered, so they only move after an edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch_in <= 4'h0;
      itr_in <= 4'h0;
      external_trigger_pin <= 1'b0;
    end
    else
    begin
      ch_in <= ch_set;
      itr_in <= itr_set;
      external_trigger_pin <= ext_set;
    end
  end
endmodule

// >>> general_purpose_timer_core_bench.sv
`timescale 1ns/10ps
`include "gpt_defs.svh"
module general_purpose_timer_core_bench;
  logic sys_clk = 1'b0; // 250 MHz
  logic rst_n = 1'b0;
  gpt_pkg::gpt_avs_req_t req = '0; // bus request
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] ch_out, ch_oe, ch_in, itr_in;
  logic irq, dma_req, trgo, ext_pin;
  logic [3:0] ch_set = 4'h0;
  logic [3:0] itr_set = 4'h0;
  logic ext_set = 1'b0;
  logic [31:0] q; // last read value
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int hi, hd;
  int md[5] = '{4, 5, 6, 7, 6};
  int pl[5] = '{0, 0, 0, 0, 1};
  int ex[5] = '{0, 12, 4, 8, 8};

  always #2 sys_clk = ~sys_clk;

  gpt_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .ch_in(ch_in),
    .external_trigger_pin(ext_pin), .itr_in(itr_in), .ch_out(ch_out),
    .ch_oe(ch_oe), .irq(irq), .dma_req(dma_req), .trgo(trgo));

  gpt_pin_model i_pins (.sys_clk(sys_clk), .rst_n(rst_n),
    .ch_set(ch_set), .itr_set(itr_set), .ext_set(ext_set),
    .ch_in(ch_in), .itr_in(itr_in), .external_trigger_pin(ext_pin));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one access; held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req <= '{read: !w, write: w, address: a, writedata: d,
             byteenable: 4'hf};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50)
    begin
      chk("bus answer", 32'h1, 32'h0);
      complete_run();
    end
    req <= '0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [6:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // cycles between two update pulses
  task automatic period(input string nm, input int e);
    int n;
    n = 0;
    while (trgo !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (trgo !== 1'b1 && n < 300);
    chk(nm, n, e);
  endtask

  // three pulses: 0 other-timer input 0, 1 trigger pin, 2 channel 1 pin
  task automatic pulses(input int src);
    repeat (3)
    begin
      if (src == 1) ext_set <= 1'b1;
      else if (src == 2) ch_set <= 4'h1;
      else itr_set <= 4'h1;
      repeat (6) @(posedge sys_clk);
      if (src == 1) ext_set <= 1'b0;
      else if (src == 2) ch_set <= 4'h0;
      else itr_set <= 4'h0;
      repeat (6) @(posedge sys_clk);
    end
  endtask

  // hang guard, more than twenty times the expected run length
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`GPT_OFS_RELOAD);
    chk("reload reset", q, 32'h0000ffff);
    rd(`GPT_OFS_PSC);
    chk("prescale reset", q, 32'h0);
    wr(7'h7c, 32'h1234);
    rd(7'h7c);
    chk("unmapped", q, 32'h0);
    $display("reset values done");
    // up, down and centre periods with reload 5
    for (int dv = 0; dv < 3; dv++)
    begin
      wr(`GPT_OFS_CTRL1, 32'h0);
      wr(`GPT_OFS_RELOAD, 32'h5);
      wr(`GPT_OFS_EVGEN, 32'h1);
      wr(`GPT_OFS_CTRL1, (dv << 2) | 1);
      period("count period", (dv == 2) ? 5 : 6);
    end
    $display("count modes done");
    // buffered prescale: the new ratio lands at the next update
    wr(`GPT_OFS_CTRL1, 32'h1);
    wr(`GPT_OFS_PSC, 32'h2);
    period("first period", 6);
    period("scaled period", 18);
    // update disable stops all update pulses
    wr(`GPT_OFS_CTRL1, 32'h3);
    wr(`GPT_OFS_RELOAD, 32'h7);
    hi = 0;
    repeat (60)
    begin
      @(posedge sys_clk);
      hi += (trgo === 1'b1);
    end
    chk("pulses while disabled", hi, 0);
    wr(`GPT_OFS_RELOAD, 32'h5);
    wr(`GPT_OFS_CTRL1, 32'h1);
    wr(`GPT_OFS_PSC, 32'h0);
    wr(`GPT_OFS_EVGEN, 32'h1);
    $display("prescale done");
    // compare modes on channel 1, compare value 2, period 6
    wr(`GPT_OFS_CC1, 32'h2);
    wr(`GPT_OFS_CTRL2, 32'h8);
    wr(`GPT_OFS_DIEN, 32'h202);
    for (int i = 0; i < 5; i++)
    begin
      wr(`GPT_OFS_CCM, md[i] << 1);
      wr(`GPT_OFS_CCEN, 1 | (pl[i] << 1));
      wr(`GPT_OFS_STS, 32'h0);
      repeat (8) @(posedge sys_clk);
      hi = 0;
      hd = 0;
      repeat (12)
      begin
        @(posedge sys_clk);
        hi += (ch_out[0] === 1'b1);
        hd += (dma_req === 1'b1);
      end
      chk("high cycles", hi, ex[i]);
      chk("dma pulses", hd, 2);
      chk("output enable", ch_oe[0], 1'b1);
      if (i == 0)
      begin
        chk("irq on forced match", irq, 1'b1);
        rd(`GPT_OFS_STS);
        chk("forced match flag", q & 32'h2, 32'h2);
      end
    end
    wr(`GPT_OFS_DIEN, 32'h0);
    $display("compare done");
    // capture on channel 2 with the counter stopped at 3
    wr(`GPT_OFS_CTRL1, 32'h0);
    wr(`GPT_OFS_CCM, 32'h100);
    wr(`GPT_OFS_CCEN, 32'h10);
    wr(`GPT_OFS_CNT, 32'h3);
    wr(`GPT_OFS_STS, 32'h0);
    ch_set <= 4'h2;
    repeat (10) @(posedge sys_clk);
    rd(`GPT_OFS_CC1 + 7'h04);
    chk("captured count", q, 32'h3);
    rd(`GPT_OFS_STS);
    chk("capture flag", q & 32'h4, 32'h4);
    ch_set <= 4'h0;
    $display("capture done");
    // slave reset mode clears the count on a trigger rise
    wr(`GPT_OFS_CNT, 32'h4);
    wr(`GPT_OFS_SMCTRL, 32'h4);
    pulses(1'b0);
    rd(`GPT_OFS_CNT);
    chk("reset mode count", q, 32'h0);
    // trigger mode starts the counter
    wr(`GPT_OFS_SMCTRL, 32'h6);
    pulses(1'b0);
    rd(`GPT_OFS_CTRL1);
    chk("trigger start", q & 32'h1, 32'h1);
    // external clock mode 1 counts rising trigger edges only
    wr(`GPT_OFS_CTRL1, 32'h0);
    wr(`GPT_OFS_SMCTRL, 32'h7);
    wr(`GPT_OFS_RELOAD, 32'hffff);
    wr(`GPT_OFS_EVGEN, 32'h1);
    wr(`GPT_OFS_CTRL1, 32'h1);
    pulses(1'b0);
    rd(`GPT_OFS_CNT);
    chk("ext mode 1 count", q, 32'h3);
    // gated mode counts every cycle while the trigger stays high
    wr(`GPT_OFS_SMCTRL, 32'h5);
    wr(`GPT_OFS_CNT, 32'h0);
    pulses(1'b0);
    rd(`GPT_OFS_CNT);
    chk("gated count", q, 32'h12);
    // external clock mode 2 counts trigger pin pulses
    wr(`GPT_OFS_SMCTRL, 32'h10000);
    wr(`GPT_OFS_CNT, 32'h0);
    pulses(1'b1);
    rd(`GPT_OFS_CNT);
    chk("ext mode 2 count", q, 32'h3);
    // channel 1 double edge: both edges of each pulse count
    wr(`GPT_OFS_SMCTRL, 32'h87);
    wr(`GPT_OFS_CNT, 32'h0);
    pulses(2);
    rd(`GPT_OFS_CNT);
    chk("double edge count", q, 32'h6);
    $display("slave modes done");
    complete_run();
  end
endmodule
